// [design/cesw_top.sv]
`default_nettype none
module cesw_top
	import cesw_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// startup card transfer
	input wire logic card_boot_sel,
	input wire logic card_boot_done,
	input wire logic card_xfer_fail,
	input wire logic card_file_missing,
	input wire logic card_absent,
	// io bus fault
	input wire logic bus_fault,
	input wire logic [7:0] bus_fault_slot,
	input wire logic [7:0] bus_fault_rack,
	// remote bus masters
	input wire logic [1:0] remote_tx_err,
	input wire logic [1:0] remote_err_clr,
	// setup table
	input wire logic setup_err,
	input wire logic [15:0] setup_err_addr,
	// excess io points
	input wire logic excess_err,
	input wire logic [2:0] excess_cause,
	input wire logic [12:0] excess_detail,
	// memory errors, one per area
	input wire logic [N_MEM_AREAS-1:0] mem_err,
	// status out
	output logic run_halt,
	output logic fault_indicator,
	output logic irq
);
	cesw_apb_if bus_if();
	assign bus_if.psel = psel;
	assign bus_if.penable = penable;
	assign bus_if.pwrite = pwrite;
	assign bus_if.paddr = paddr;
	assign bus_if.pwdata = pwdata;
	assign prdata = bus_if.prdata;
	assign pready = bus_if.pready;
	assign pslverr = bus_if.pslverr;

	logic wr_stb;
	logic rd_hit;
	logic [31:0] rd_word;
	cesw_apb_slave u_slave (
		.pclk(pclk),
		.presetn(presetn),
		.bus(bus_if.slave),
		.wr_stb(wr_stb),
		.rd_hit(rd_hit),
		.rd_word(rd_word)
	);

	logic card_flag_ff;
	logic [15:0] bus_loc_ff;
	logic [1:0] remote_ff;
	logic [15:0] setup_loc_ff;
	logic [15:0] excess_ff;
	logic halt_ff;
	logic [N_IRQ-1:0] irq_stat_ff;
	logic [N_IRQ-1:0] irq_mask_ff;
	logic ind_en_ff;
	logic [31:0] flash_cnt_ff;
	logic flash_ff;
	logic [N_MEM_AREAS-1:0] prev_mem_ff;
	logic [1:0] prev_remote_ff;

	// card failure causes
	logic card_fail;
	assign card_fail = card_boot_sel & card_boot_done
		& (card_xfer_fail | card_file_missing | card_absent);

	// range checks: out-of-range reports are dropped, not clipped
	logic bus_ok;
	logic setup_ok;
	logic excess_ok;
	logic [15:0] nxt_bus_loc;
	assign bus_ok = (bus_fault_slot <= SLOT_MAX) & (bus_fault_rack <= RACK_MAX);
	assign nxt_bus_loc = {bus_fault_rack, bus_fault_slot};
	assign setup_ok = (setup_err_addr >= SETUP_LOC_MIN) & (setup_err_addr <= SETUP_LOC_MAX);
	assign excess_ok = excess_cause <= CAUSE_MAX;
	logic [15:0] nxt_excess;
	assign nxt_excess = {excess_cause, excess_detail};

	// per-cause sanity: causes 2,3 report only real excesses
	logic cause_valid;
	assign cause_valid =
		(excess_cause == CAUSE_INT_INPUTS) ? (excess_detail > INT_INPUT_LIMIT) :
		(excess_cause == CAUSE_SLAVE_POINTS) ? (excess_detail > SLAVE_POINT_LIMIT) :
		1'b1;

	// memory area map
	logic [15:0] mem_word;
	localparam int MEM_POS [N_MEM_AREAS] = '{MEM_BIT_PROG, MEM_BIT_SETUP, MEM_BIT_IOTAB,
		MEM_BIT_ROUTE, MEM_BIT_BUSUNIT};
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_mem
			if (gi == MEM_BIT_CARD) begin : g_card
				assign mem_word[gi] = card_flag_ff;
			end else if (gi == MEM_POS[0] || gi == MEM_POS[1] || gi == MEM_POS[2]
				|| gi == MEM_POS[3] || gi == MEM_POS[4]) begin : g_area
				localparam int IDX = (gi == MEM_POS[0]) ? 0 : (gi == MEM_POS[1]) ? 1 :
					(gi == MEM_POS[2]) ? 2 : (gi == MEM_POS[3]) ? 3 : 4;
				assign mem_word[gi] = mem_err[IDX];
			end else begin : g_zero
				assign mem_word[gi] = 1'b0;
			end
		end
	endgenerate

	// events
	logic [N_IRQ-1:0] evt;
	assign evt[IRQ_CARD] = card_fail & ~card_flag_ff;
	assign evt[IRQ_BUS] = bus_fault & bus_ok;
	assign evt[IRQ_REMOTE] = |(remote_tx_err & ~prev_remote_ff);
	assign evt[IRQ_SETUP] = setup_err & setup_ok;
	assign evt[IRQ_EXCESS] = excess_err & excess_ok & cause_valid;
	assign evt[IRQ_MEM] = |(mem_err & ~prev_mem_ff);

	// address decode, one named hit per word
	logic hit_mem;
	logic hit_bus;
	logic hit_remote;
	logic hit_setup;
	logic hit_excess;
	logic hit_stat;
	logic hit_mask;
	logic hit_ctrl;
	assign hit_mem = paddr == ADDR_MEM_ERR;
	assign hit_bus = paddr == ADDR_BUS_FAULT;
	assign hit_remote = paddr == ADDR_REMOTE;
	assign hit_setup = paddr == ADDR_SETUP;
	assign hit_excess = paddr == ADDR_EXCESS;
	assign hit_stat = paddr == ADDR_IRQ_STAT;
	assign hit_mask = paddr == ADDR_IRQ_MASK;
	assign hit_ctrl = paddr == ADDR_CTRL;

	// writes only touch irq and control registers
	logic wr_stat;
	logic wr_mask;
	logic wr_ctrl;
	assign wr_stat = wr_stb & hit_stat;
	assign wr_mask = wr_stb & hit_mask;
	assign wr_ctrl = wr_stb & hit_ctrl;
	logic [N_IRQ-1:0] clr_stat;
	assign clr_stat = {N_IRQ{wr_stat}} & pwdata[N_IRQ-1:0];
	logic [N_IRQ-1:0] nxt_irq_stat;
	assign nxt_irq_stat = (irq_stat_ff & ~clr_stat) | evt;
	logic [N_IRQ-1:0] nxt_irq_mask;
	assign nxt_irq_mask = wr_mask ? pwdata[N_IRQ-1:0] : irq_mask_ff;
	logic nxt_ind_en;
	assign nxt_ind_en = wr_ctrl ? pwdata[0] : ind_en_ff;

	// readback words, zero-extended to the bus width
	logic [31:0] word_mem;
	logic [31:0] word_bus;
	logic [31:0] word_remote;
	logic [31:0] word_setup;
	logic [31:0] word_excess;
	logic [31:0] word_stat;
	logic [31:0] word_mask;
	logic [31:0] word_ctrl;
	assign word_mem = {16'h0000, mem_word};
	assign word_bus = {16'h0000, bus_loc_ff};
	assign word_remote = {30'h0, remote_ff};
	assign word_setup = {16'h0000, setup_loc_ff};
	assign word_excess = {16'h0000, excess_ff};
	assign word_stat = {26'h0, irq_stat_ff};
	assign word_mask = {26'h0, irq_mask_ff};
	assign word_ctrl = {30'h0, halt_ff, ind_en_ff};
	logic [31:0] sel_word;
	assign sel_word = ({32{hit_mem}} & word_mem)
		| ({32{hit_bus}} & word_bus)
		| ({32{hit_remote}} & word_remote)
		| ({32{hit_setup}} & word_setup)
		| ({32{hit_excess}} & word_excess)
		| ({32{hit_stat}} & word_stat)
		| ({32{hit_mask}} & word_mask)
		| ({32{hit_ctrl}} & word_ctrl);
	// unmapped addresses read as zero; the slave flags the error
	assign rd_word = rd_hit ? sel_word : 32'h0000_0000;

	// card flag has no clear path besides power-on reset
	logic nxt_card_flag;
	assign nxt_card_flag = card_flag_ff | card_fail;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			card_flag_ff <= 1'b0;
		end else begin
			card_flag_ff <= nxt_card_flag;
		end
	end

	// error words never load from the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_loc_ff <= WORD_RESET;
		end else if (evt[IRQ_BUS]) begin
			bus_loc_ff <= nxt_bus_loc;
		end
	end

	// hardware set wins over firmware clear
	logic [1:0] nxt_remote;
	assign nxt_remote = (remote_ff & ~remote_err_clr) | remote_tx_err;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_ff <= 2'h0;
			prev_remote_ff <= 2'h0;
		end else begin
			remote_ff <= nxt_remote;
			prev_remote_ff <= remote_tx_err;
		end
	end

	// frozen once halted so the first cause stays readable
	logic ld_excess;
	assign ld_excess = evt[IRQ_EXCESS] & ~halt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			excess_ff <= WORD_RESET;
		end else if (ld_excess) begin
			excess_ff <= nxt_excess;
		end
	end

	// setup location follows its cause
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_loc_ff <= WORD_RESET;
		end else if (evt[IRQ_SETUP]) begin
			setup_loc_ff <= setup_err_addr;
		end else if (!setup_err) begin
			setup_loc_ff <= WORD_RESET;
		end
	end

	// excess points halts until reset
	logic nxt_halt;
	assign nxt_halt = halt_ff | evt[IRQ_EXCESS];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_ff <= 1'b0;
		end else begin
			halt_ff <= nxt_halt;
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= '0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_ff <= '0;
		end else begin
			irq_mask_ff <= nxt_irq_mask;
		end
	end

	// enable comes up set so faults show from power-on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_en_ff <= 1'b1;
		end else begin
			ind_en_ff <= nxt_ind_en;
		end
	end

	// idle level is low, so reset gives no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_mem_ff <= '0;
		end else begin
			prev_mem_ff <= mem_err;
		end
	end

	// indicator mode: halt beats flashing errors
	cesw_ind_t ind_mode;
	logic nonfatal;
	logic mem_any;
	logic setup_pending;
	assign mem_any = |mem_err;
	assign setup_pending = setup_loc_ff != WORD_RESET;
	assign nonfatal = setup_pending | mem_any;
	always_comb begin
		if (halt_ff) begin
			ind_mode = IND_STEADY;
		end else if (nonfatal) begin
			ind_mode = IND_FLASH;
		end else begin
			ind_mode = IND_OFF;
		end
	end

	// long period: a short run never sees the lit flash phase
	logic flash_wrap;
	logic [31:0] nxt_flash_cnt;
	assign flash_wrap = flash_cnt_ff == FLASH_CYCLES - 1;
	assign nxt_flash_cnt = flash_wrap ? 32'h0000_0000 : flash_cnt_ff + 32'h0000_0001;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_cnt_ff <= '0;
			flash_ff <= 1'b0;
		end else begin
			flash_cnt_ff <= nxt_flash_cnt;
			if (flash_wrap) begin
				flash_ff <= ~flash_ff;
			end
		end
	end

	logic ind_raw;
	always_comb begin
		case (ind_mode)
			IND_STEADY: ind_raw = 1'b1;
			IND_FLASH: ind_raw = flash_ff;
			IND_OFF: ind_raw = 1'b0;
			default: ind_raw = 1'b0;
		endcase
	end
	assign fault_indicator = ind_raw & ind_en_ff;
	// setup errors never stop the run
	assign run_halt = halt_ff;
	assign irq = |(irq_stat_ff & irq_mask_ff);
endmodule
`default_nettype wire

// [design/cesw_pkg.sv]
// Function
// - card boot failure sets startup transfer flag
// - startup transfer flag clears only at power-off
// - bus fault slot, 0..9, low byte
// - bus fault rack, 0..7, high byte
// - remote master fault flags, bits 0/1
// - setup error address 000a..009f, whole word
// - setup error keeps running, indicator flashes
// - setup error word cleared when cause gone
// - excess points cause code in bits 13..15
// - excess points detail in bits 0..12
// - excess points halts run, indicator steady
// - causes one, two: point and interrupt counts
// - cause three: slave unit over 320 points
// - causes four..six: duplicates, racks count
// - memory error bits 0,4,5,7,8 by area
`default_nettype none
package cesw_pkg;
	localparam logic [7:0] ADDR_MEM_ERR = 8'h00;
	localparam logic [7:0] ADDR_BUS_FAULT = 8'h04;
	localparam logic [7:0] ADDR_REMOTE = 8'h08;
	localparam logic [7:0] ADDR_SETUP = 8'h0c;
	localparam logic [7:0] ADDR_EXCESS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
	localparam logic [7:0] ADDR_CTRL = 8'h1c;
	localparam int MEM_BIT_PROG = 0;
	localparam int MEM_BIT_SETUP = 4;
	localparam int MEM_BIT_IOTAB = 5;
	localparam int MEM_BIT_ROUTE = 7;
	localparam int MEM_BIT_BUSUNIT = 8;
	localparam int MEM_BIT_CARD = 9;
	localparam int N_MEM_AREAS = 5;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0] SLOT_MAX = 8'h09;
	localparam logic [7:0] RACK_MAX = 8'h07;
	localparam logic [15:0] SETUP_LOC_MIN = 16'h000a;
	localparam logic [15:0] SETUP_LOC_MAX = 16'h009f;
	localparam logic [2:0] CAUSE_MAX = 3'h5;
	localparam logic [12:0] INT_INPUT_LIMIT = 13'h0020;
	localparam logic [12:0] SLAVE_POINT_LIMIT = 13'h0140;
	localparam int CAUSE_LSB = 13;
	// flash toggles every 0.25 s at 200 MHz, 0.5 s period
	localparam int FLASH_MS = 250;
	localparam int CLK_MHZ = 200;
	localparam int FLASH_CYCLES = FLASH_MS * 1000 * CLK_MHZ;
	localparam int N_IRQ = 6;
	localparam int IRQ_CARD = 0;
	localparam int IRQ_BUS = 1;
	localparam int IRQ_REMOTE = 2;
	localparam int IRQ_SETUP = 3;
	localparam int IRQ_EXCESS = 4;
	localparam int IRQ_MEM = 5;
	typedef enum logic [2:0] {
		CAUSE_IO_POINTS,
		CAUSE_INT_INPUTS,
		CAUSE_SLAVE_POINTS,
		CAUSE_TERM_DUP,
		CAUSE_MASTER_UNIT,
		CAUSE_RACK_COUNT
	} cesw_cause_t;
	typedef enum logic [1:0] {
		IND_OFF,
		IND_FLASH,
		IND_STEADY
	} cesw_ind_t;
endpackage
`default_nettype wire

// [design/cesw_apb_if.sv]
`default_nettype none
interface cesw_apb_if;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	modport slave (input psel, penable, pwrite, paddr, pwdata,
		output prdata, pready, pslverr);
	modport core (output psel, penable, pwrite, paddr, pwdata,
		input prdata, pready, pslverr);
endinterface
`default_nettype wire

// [design/cesw_apb_slave.sv]
`default_nettype none
module cesw_apb_slave
	import cesw_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bus side
	cesw_apb_if.slave bus,
	// register side
	output logic wr_stb,
	output logic rd_hit,
	input wire logic [31:0] rd_word
);
	logic [31:0] prdata_ff;
	logic access;
	logic [7:0] a;
	assign access = bus.psel & bus.penable;
	assign a = bus.paddr;
	assign rd_hit = (a == ADDR_MEM_ERR) | (a == ADDR_BUS_FAULT) | (a == ADDR_REMOTE)
		| (a == ADDR_SETUP) | (a == ADDR_EXCESS) | (a == ADDR_IRQ_STAT)
		| (a == ADDR_IRQ_MASK) | (a == ADDR_CTRL);
	assign wr_stb = access & bus.pwrite;
	// single wait-free access; unmapped reads return zero with pslverr
	assign bus.pready = 1'b1;
	assign bus.pslverr = access & ~rd_hit;
	assign bus.prdata = prdata_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (bus.psel & ~bus.penable & ~bus.pwrite) begin
			prdata_ff <= rd_word;
		end
	end
endmodule
`default_nettype wire

// [sim/cesw_chk.sv]
`default_nettype none
module cesw_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// events and status
	input wire logic setup_err,
	input wire logic excess_err,
	input wire logic [2:0] excess_cause,
	input wire logic [12:0] excess_detail,
	input wire logic run_halt,
	input wire logic fault_indicator
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	a_ready_high: assert property (s_access |-> pready)
		else $error("ready low in access");
	a_unmapped_err: assert property ((s_access ##0 paddr > 8'h1c) |-> pslverr)
		else $error("no error on unmapped access");
	a_mapped_ok: assert property ((s_access ##0 paddr <= 8'h1c) |-> !pslverr)
		else $error("error on mapped access");
	a_upper_zero: assert property (s_setup |=> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_unmapped_zero: assert property ((s_setup ##0 (!pwrite && paddr > 8'h1c)) |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_halt_excess: assert property (excess_err && excess_cause <= 3'h5
		&& excess_detail > 13'h0140 |-> ##[1:2] run_halt) else $error("no halt");
	a_halt_hold: assert property (run_halt |=> run_halt)
		else $error("halt released");
	a_ind_steady: assert property (run_halt [*2] |-> fault_indicator)
		else $error("indicator not steady");
	a_setup_runs: assert property (setup_err && !excess_err && !run_halt |=> !run_halt)
		else $error("setup error halted");
endmodule
bind cesw_top cesw_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .setup_err, .excess_err, .excess_cause, .excess_detail, .run_halt,
	.fault_indicator);
`default_nettype wire

// [sim/cesw_fw_model.sv]
`default_nettype none
module cesw_fw_model (
	// clock
	input wire logic pclk,
	// event strobes and payload
	output logic [3:0] stb,
	output logic [15:0] pay,
	// held conditions
	output logic setup_err,
	output logic [15:0] setup_err_addr,
	output logic [4:0] mem_err
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		stb = 4'h0;
		pay = 16'h0000;
		setup_err = 1'b0;
		setup_err_addr = 16'h0000;
		mem_err = 5'h00;
	end
	// payload inverted after the strobe so a late sample shows
	task automatic pulse(input int k, input logic [15:0] v);
		@(posedge pclk);
		stb[k] <= 1'b1;
		pay <= v;
		@(posedge pclk);
		stb[k] <= 1'b0;
		pay <= ~v;
	endtask
	task automatic hold(input logic on, input logic [15:0] a, input logic [4:0] m);
		@(posedge pclk);
		setup_err <= on;
		setup_err_addr <= a;
		mem_err <= m;
	endtask
endmodule
`default_nettype wire

// [sim/tb_controller_error_status_words.sv]
`default_nettype none
module tb_controller_error_status_words import cesw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, run_halt, fault_indicator, irq, pready, pslverr, a;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] stb;
	logic [15:0] pay, setup_addr, v;
	logic setup_on;
	logic [4:0] mem_err;
	logic [31:0] exp_q[$];
	int bad_count = 0;
	int checks = 0;
	integer seed = 93;
	initial forever #2.5 pclk = ~pclk;
	cesw_fw_model fw (.pclk, .stb, .pay, .setup_err(setup_on), .setup_err_addr(setup_addr),
		.mem_err);
	cesw_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .card_boot_sel(pay[15]), .card_boot_done(stb[0]), .card_xfer_fail(pay[0]),
		.card_file_missing(pay[1]), .card_absent(pay[2]), .bus_fault(stb[1]),
		.bus_fault_slot(pay[7:0]), .bus_fault_rack(pay[15:8]),
		.remote_tx_err({2{stb[2]}} & pay[1:0]), .remote_err_clr(2'h0), .setup_err(setup_on),
		.setup_err_addr(setup_addr), .excess_err(stb[3]), .excess_cause(pay[15:13]),
		.excess_detail(pay[12:0]), .mem_err, .run_halt, .fault_indicator, .irq);
	task automatic stop_test();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, ad, 32'h0);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			chk(prdata, exp_q.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		stop_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		fw.pulse(0, 16'h0007);
		rd(ADDR_MEM_ERR, 32'h0);
		fw.pulse(0, 16'h8000);
		rd(ADDR_MEM_ERR, 32'h0);
		fw.pulse(0, 16'h8004);
		rd(ADDR_MEM_ERR, 32'h200);
		apb(1'b1, ADDR_MEM_ERR, 32'h0);
		apb(1'b1, ADDR_IRQ_STAT, 32'h3f);
		fw.hold(1'b0, 16'h0000, 5'h1f);
		rd(ADDR_MEM_ERR, 32'h3b1);
		v = {8'($unsigned($random(seed)) % 8), 8'($unsigned($random(seed)) % 10)};
		fw.pulse(1, v);
		rd(ADDR_BUS_FAULT, {16'h0, v});
		fw.pulse(1, 16'h000a);
		apb(1'b1, ADDR_BUS_FAULT, 32'hffff);
		rd(ADDR_BUS_FAULT, {16'h0, v});
		fw.pulse(2, 16'h0001);
		rd(ADDR_REMOTE, 32'h1);
		fw.pulse(2, 16'h0002);
		rd(ADDR_REMOTE, 32'h3);
		rd(8'h20, 32'h0);
		for (int k = 0; k < 2; k++) begin
			v = k ? 16'h009f : 16'h000a;
			fw.hold(1'b1, v, 5'h00);
			rd(ADDR_SETUP, {16'h0, v});
			fw.hold(1'b0, v, 5'h00);
			rd(ADDR_SETUP, 32'h0);
		end
		apb(1'b1, ADDR_IRQ_STAT, 32'h3f);
		rd(ADDR_IRQ_STAT, 32'h0);
		fw.pulse(2, 16'h0001);
		rd(ADDR_IRQ_STAT, 32'h4);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0);
		@(negedge pclk);
		a = irq;
		apb(1'b1, ADDR_IRQ_MASK, 32'h3f);
		@(negedge pclk);
		chk({31'h0, a ^ irq}, 32'h1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h4);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
		rd(ADDR_CTRL, 32'h1);
		@(negedge pclk);
		chk({30'h0, run_halt, fault_indicator}, 32'h0);
		// mid-run resets let every cause be seen, the word freezes at halt
		for (int c = 0; c < 6; c++) begin
			@(posedge pclk);
			presetn <= 1'b0;
			repeat (12) @(posedge pclk);
			presetn <= 1'b1;
			rd(ADDR_REMOTE, 32'h0);
			rd(ADDR_MEM_ERR, 32'h0);
			v = {3'(c), 13'h0141 + 13'($unsigned($random(seed)) % 256)};
			fw.pulse(3, v);
			fw.pulse(3, ~v);
			rd(ADDR_EXCESS, {16'h0, v});
			rd(ADDR_CTRL, 32'h3);
			@(negedge pclk);
			chk({30'h0, run_halt, fault_indicator}, 32'h3);
		end
		repeat (2) @(posedge pclk);
		stop_test();
	end
endmodule
`default_nettype wire
